// File: logic/sncr_map.svh
// Register numbers, field positions, reset values and limits of the node configuration bank
`ifndef SNCR_MAP_SVH
`define SNCR_MAP_SVH
`define SNCR_REG_IDENT      8'h00
`define SNCR_REG_DESC       8'h01
`define SNCR_REG_CONFIG     8'h04
`define SNCR_REG_NODE_ID    8'h05
`define SNCR_REG_PLL        8'h06
`define SNCR_REG_SW_DIV     8'h07
`define SNCR_REG_REF_DIV    8'h08
`define SNCR_REG_JTAG_ID    8'h09
`define SNCR_REG_USER_CODE  8'h0A
`define SNCR_REG_DIR_LOW    8'h0C
`define SNCR_REG_DIR_HIGH   8'h0D
`define SNCR_REG_RSV_A      8'h10
`define SNCR_REG_RSV_B      8'h11
`define SNCR_REG_DBG_SRC    8'h1F
`define SNCR_CFG_LOCK_ALL   31
`define SNCR_CFG_LOCK_PLL   8
`define SNCR_CFG_HDR_ONE    0
`define SNCR_PLL_NO_RESET   31
`define SNCR_PLL_NO_WAIT    30
`define SNCR_PLL_BYPASS     29
`define SNCR_PLL_JTAG_BOOT  28
`define SNCR_PLL_P_HI       25
`define SNCR_PLL_P_LO       23
`define SNCR_PLL_M_HI       20
`define SNCR_PLL_M_LO       8
`define SNCR_PLL_N_HI       6
`define SNCR_PLL_N_LO       0
`define SNCR_PLL_M_MAX      13'h00FE
`define SNCR_PLL_N_MAX      7'h0F
`define SNCR_PLL_WMASK      32'hF39F_FF7F
`define SNCR_PLL_RST        32'h0000_0000
`define SNCR_REF_DIV_RST    16'h0003
`define SNCR_ID_PINS_LO     16
`define SNCR_ID_REV_LO      8
`define SNCR_UCODE_LO       18
`define SNCR_SYNC_FILL      2'h3
`endif

// File: logic/sncr_pkg.sv
// Types of the node configuration bank
package sncr_pkg;
    typedef enum logic [1:0] {
        SNCR_PLL_IDLE,
        SNCR_PLL_BLANK,
        SNCR_PLL_WAIT
    } sncr_pll_state_t;

    typedef struct packed {
        logic [7:0]      boot_s1;
        logic [7:0]      boot_s2;
        logic [7:0]      boot_s3;
        logic [1:0]      fill;
        logic            boot_done;
        logic [7:0]      boot_pins;
        logic [2:0]      lock_s;
        logic            lock_all;
        logic            lock_pll;
        logic            hdr_one;
        logic [15:0]     node_id;
        logic [31:0]     pll;
        logic [15:0]     sw_div;
        logic [15:0]     ref_div;
        logic [31:0]     dir_low;
        logic [31:0]     dir_high;
        logic [1:0]      rsv_a;
        logic [1:0]      rsv_b;
        sncr_pll_state_t pll_st;
        logic [15:0]     blank_cnt;
        logic            tile_reset;
        logic            relock_wait;
        logic            ack;
        logic            err;
        logic [31:0]     rdata;
        logic            route_valid;
        logic            route_local;
        logic [3:0]      route_dir;
    } sncr_state_t;
endpackage : sncr_pkg

// File: logic/sncr_regs.sv
// Node configuration register bank with routing direction lookup
`timescale 1ns/1ps
`include "sncr_map.svh"

module sncr_regs
    import sncr_pkg::*;
#(
    parameter logic [7:0]  SWITCH_VERSION    = 8'h01,
    parameter logic [7:0]  SWITCH_REVISION   = 8'h00,
    parameter logic [7:0]  NUM_SERIAL_LINKS  = 8'h08,
    parameter logic [7:0]  NUM_SWITCH_PROCS  = 8'h02,
    parameter logic [7:0]  NUM_DEVICE_PROCS  = 8'h02,
    // Arbitrary identity values, not those of any real part
    parameter logic [31:0] JTAG_IDENTITY     = 32'h0000_0001,
    parameter logic [17:0] METAL_ID_CODE     = 18'h0_0000,
    parameter logic [15:0] PLL_BLANK_CYCLES  = 16'h0010
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Configuration access
    input  wire logic        cfg_req_i,
    input  wire logic        cfg_write_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic             cfg_error_o,
    output logic [31:0]      cfg_rdata_o,
    // Pins and on-chip sources
    input  wire logic [7:0]  boot_control_pins_i,
    input  wire logic        pll_locked_i,
    input  wire logic [13:0] otp_user_code_i,
    input  wire logic [1:0]  debug_source_i,
    // Route lookup
    input  wire logic        route_req_i,
    input  wire logic [15:0] route_dest_i,
    output logic             route_valid_o,
    output logic             route_local_o,
    output logic [3:0]       route_dir_o,
    // Configuration outputs
    output logic             header_one_byte_o,
    output logic [15:0]      node_id_o,
    output logic             pll_bypass_o,
    output logic             boot_from_jtag_o,
    output logic [2:0]       pll_out_div_o,
    output logic [12:0]      pll_fb_mult_o,
    output logic [6:0]       pll_in_div_o,
    output logic [15:0]      switch_clk_div_o,
    output logic [15:0]      ref_clk_div_o,
    output logic             tile_reset_o,
    output logic             pll_relock_wait_o
);

    sncr_state_t st;
    sncr_state_t next_st;

    logic        wr;
    logic        rd;
    logic        wr_ok;
    logic        ctl_lock;
    logic [31:0] pll_w;
    logic [12:0] m_w;
    logic [6:0]  n_w;
    logic [15:0] diff;
    logic [3:0]  msb;
    logic        found;
    logic        pll_wr_ok;

    // Direction field of one dimension; each table holds eight 4-bit fields
    function automatic logic [3:0] sncr_dir_field(
        input logic [31:0] tbl,
        input logic [2:0]  dim
    );
        logic [3:0] f;
        f = tbl[{dim, 2'h0} +: 4];
        return f;
    endfunction : sncr_dir_field

    always_comb begin
        next_st = st;
        wr      = cfg_req_i && cfg_write_i;
        rd      = cfg_req_i && !cfg_write_i;
        ctl_lock = st.lock_all;
        wr_ok   = 1'b0;
        pll_w   = cfg_wdata_i & `SNCR_PLL_WMASK;
        m_w     = pll_w[`SNCR_PLL_M_HI:`SNCR_PLL_M_LO];
        n_w     = pll_w[`SNCR_PLL_N_HI:`SNCR_PLL_N_LO];
        diff    = route_dest_i ^ st.node_id;
        msb     = 4'h0;
        found   = 1'b0;
        pll_wr_ok = 1'b0;

        // Three-stage synchronisers for pins from outside the clock domain
        next_st.boot_s1 = boot_control_pins_i;
        next_st.boot_s2 = st.boot_s1;
        next_st.boot_s3 = st.boot_s2;
        next_st.lock_s  = {st.lock_s[1:0], pll_locked_i};

        // Boot pins are taken once, after the chain has refilled since reset
        if (st.fill != `SNCR_SYNC_FILL) begin
            next_st.fill = st.fill + 2'h1;
        end else if (!st.boot_done && st.boot_s2 == st.boot_s3) begin
            next_st.boot_pins = st.boot_s3;
            next_st.boot_done = 1'b1;
        end

        // Pulses last one cycle
        next_st.ack        = 1'b0;
        next_st.err        = 1'b0;
        next_st.tile_reset = 1'b0;

        if (cfg_req_i) begin
            next_st.ack = 1'b1;
        end

        if (rd) begin
            next_st.rdata = 32'h0000_0000;
            case (cfg_addr_i)
                `SNCR_REG_IDENT: begin
                    next_st.rdata[23:`SNCR_ID_PINS_LO] = st.boot_pins;
                    next_st.rdata[15:`SNCR_ID_REV_LO]  = SWITCH_REVISION;
                    next_st.rdata[7:0]                 = SWITCH_VERSION;
                end

                `SNCR_REG_DESC: begin
                    next_st.rdata[23:16] = NUM_SERIAL_LINKS;
                    next_st.rdata[15:8]  = NUM_SWITCH_PROCS;
                    next_st.rdata[7:0]   = NUM_DEVICE_PROCS;
                end

                `SNCR_REG_CONFIG: begin
                    next_st.rdata[`SNCR_CFG_LOCK_ALL] = st.lock_all;
                    next_st.rdata[`SNCR_CFG_LOCK_PLL] = st.lock_pll;
                    next_st.rdata[`SNCR_CFG_HDR_ONE]  = st.hdr_one;
                end

                `SNCR_REG_NODE_ID: begin
                    next_st.rdata[15:0] = st.node_id;
                end

                `SNCR_REG_PLL: begin
                    next_st.rdata = st.pll;
                end

                `SNCR_REG_SW_DIV: begin
                    next_st.rdata[15:0] = st.sw_div;
                end

                `SNCR_REG_REF_DIV: begin
                    next_st.rdata[15:0] = st.ref_div;
                end

                `SNCR_REG_JTAG_ID: begin
                    next_st.rdata = JTAG_IDENTITY;
                end

                `SNCR_REG_USER_CODE: begin
                    next_st.rdata[31:`SNCR_UCODE_LO] = otp_user_code_i;
                    next_st.rdata[17:0]              = METAL_ID_CODE;
                end

                `SNCR_REG_DIR_LOW: begin
                    next_st.rdata = st.dir_low;
                end

                `SNCR_REG_DIR_HIGH: begin
                    next_st.rdata = st.dir_high;
                end

                `SNCR_REG_RSV_A: begin
                    next_st.rdata[1:0] = st.rsv_a;
                end

                `SNCR_REG_RSV_B: begin
                    next_st.rdata[1:0] = st.rsv_b;
                end

                `SNCR_REG_DBG_SRC: begin
                    next_st.rdata[1:0] = debug_source_i;
                end
                default: begin
                    next_st.err = 1'b1;
                end
            endcase
        end

        if (wr) begin
            // Lock bit covers the configuration register too, so it holds until reset
            case (cfg_addr_i)
                `SNCR_REG_CONFIG: begin
                    if (!ctl_lock) begin
                        wr_ok            = 1'b1;
                        next_st.lock_all = cfg_wdata_i[`SNCR_CFG_LOCK_ALL];
                        next_st.lock_pll = cfg_wdata_i[`SNCR_CFG_LOCK_PLL];
                        next_st.hdr_one  = cfg_wdata_i[`SNCR_CFG_HDR_ONE];
                    end
                end

                `SNCR_REG_NODE_ID: begin
                    if (!ctl_lock) begin
                        wr_ok           = 1'b1;
                        next_st.node_id = cfg_wdata_i[15:0];
                    end
                end

                `SNCR_REG_PLL: begin
                    if (!ctl_lock && !st.lock_pll) begin
                        wr_ok = 1'b1;
                        pll_wr_ok = 1'b1;
                        // Codes beyond the largest legal ratio are held at the limit
                        if (m_w > `SNCR_PLL_M_MAX) begin
                            m_w = `SNCR_PLL_M_MAX;
                        end
                        if (n_w > `SNCR_PLL_N_MAX) begin
                            n_w = `SNCR_PLL_N_MAX;
                        end
                        pll_w[`SNCR_PLL_M_HI:`SNCR_PLL_M_LO] = m_w;
                        pll_w[`SNCR_PLL_N_HI:`SNCR_PLL_N_LO] = n_w;
                        next_st.pll = pll_w;
                        next_st.tile_reset = !pll_w[`SNCR_PLL_NO_RESET];
                        if (!pll_w[`SNCR_PLL_NO_WAIT]) begin
                            next_st.pll_st      = SNCR_PLL_BLANK;
                            next_st.blank_cnt   = PLL_BLANK_CYCLES;
                            next_st.relock_wait = 1'b1;
                        end else begin
                            next_st.pll_st      = SNCR_PLL_IDLE;
                            next_st.relock_wait = 1'b0;
                        end
                    end
                end
                `SNCR_REG_SW_DIV: begin
                    if (!ctl_lock) begin
                        wr_ok          = 1'b1;
                        next_st.sw_div = cfg_wdata_i[15:0];
                    end
                end

                `SNCR_REG_REF_DIV: begin
                    if (!ctl_lock) begin
                        wr_ok           = 1'b1;
                        next_st.ref_div = cfg_wdata_i[15:0];
                    end
                end

                `SNCR_REG_DIR_LOW: begin
                    if (!ctl_lock) begin
                        wr_ok           = 1'b1;
                        next_st.dir_low = cfg_wdata_i;
                    end
                end

                `SNCR_REG_DIR_HIGH: begin
                    if (!ctl_lock) begin
                        wr_ok            = 1'b1;
                        next_st.dir_high = cfg_wdata_i;
                    end
                end

                `SNCR_REG_RSV_A: begin
                    if (!ctl_lock) begin
                        wr_ok         = 1'b1;
                        next_st.rsv_a = cfg_wdata_i[1:0];
                    end
                end

                `SNCR_REG_RSV_B: begin
                    if (!ctl_lock) begin
                        wr_ok         = 1'b1;
                        next_st.rsv_b = cfg_wdata_i[1:0];
                    end
                end

                default: begin
                    wr_ok = 1'b0;
                end
            endcase
            next_st.err = !wr_ok;
        end

        // Relock wait: lock may still read high just after the write, so blank first
        if (!pll_wr_ok) begin
            case (st.pll_st)
                SNCR_PLL_IDLE: begin
                    next_st.relock_wait = 1'b0;
                end
                SNCR_PLL_BLANK: begin
                    if (st.blank_cnt <= 16'h0001) begin
                        next_st.pll_st = SNCR_PLL_WAIT;
                    end else begin
                        next_st.blank_cnt = st.blank_cnt - 16'h0001;
                    end
                end
                SNCR_PLL_WAIT: begin
                    if (st.lock_s[1] && st.lock_s[2]) begin
                        next_st.pll_st      = SNCR_PLL_IDLE;
                        next_st.relock_wait = 1'b0;
                    end
                end
                default: begin
                    next_st.pll_st      = SNCR_PLL_IDLE;
                    next_st.relock_wait = 1'b0;
                end
            endcase
        end

        // Most significant mismatching bit picks the dimension
        for (int i = 0; i < 16; i++) begin
            if (diff[i]) begin
                msb   = 4'(i);
                found = 1'b1;
            end
        end
        next_st.route_valid = route_req_i;
        if (route_req_i) begin
            next_st.route_local = !found;
            if (!found) begin
                next_st.route_dir = 4'h0;
            end else if (msb[3]) begin
                next_st.route_dir = sncr_dir_field(st.dir_high, msb[2:0]);
            end else begin
                next_st.route_dir = sncr_dir_field(st.dir_low, msb[2:0]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st             <= '0;
            st.lock_all    <= 1'b0;
            st.lock_pll    <= 1'b0;
            st.hdr_one     <= 1'b0;
            st.node_id     <= '0;
            st.pll         <= `SNCR_PLL_RST;
            st.sw_div      <= '0;
            st.ref_div     <= `SNCR_REF_DIV_RST;
            st.dir_low     <= '0;
            st.dir_high    <= '0;
            st.rsv_a       <= '0;
            st.rsv_b       <= '0;
            st.pll_st      <= SNCR_PLL_IDLE;
            st.tile_reset  <= 1'b0;
            st.relock_wait <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Access answer
    assign cfg_ack_o   = st.ack;
    assign cfg_error_o = st.err;
    assign cfg_rdata_o = st.rdata;

    // Route answer
    assign route_valid_o = st.route_valid;
    assign route_local_o = st.route_local;
    assign route_dir_o   = st.route_dir;

    // Configuration fields
    assign header_one_byte_o = st.hdr_one;
    assign node_id_o         = st.node_id;
    assign pll_bypass_o      = st.pll[`SNCR_PLL_BYPASS];
    assign boot_from_jtag_o  = st.pll[`SNCR_PLL_JTAG_BOOT];
    assign pll_out_div_o     = st.pll[`SNCR_PLL_P_HI:`SNCR_PLL_P_LO];
    assign pll_fb_mult_o     = st.pll[`SNCR_PLL_M_HI:`SNCR_PLL_M_LO];
    assign pll_in_div_o      = st.pll[`SNCR_PLL_N_HI:`SNCR_PLL_N_LO];
    assign switch_clk_div_o  = st.sw_div;
    assign ref_clk_div_o     = st.ref_div;
    assign tile_reset_o      = st.tile_reset;
    assign pll_relock_wait_o = st.relock_wait;

endmodule : sncr_regs

// File: dv/sncr_regs_sva.sv
// Port checker of the node configuration bank
`timescale 1ns/1ps
module sncr_regs_sva (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // Configuration access
    input wire logic        cfg_req_i,
    input wire logic        cfg_write_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic        cfg_ack_o,
    input wire logic        cfg_error_o,
    // Route lookup
    input wire logic        route_req_i,
    input wire logic [15:0] route_dest_i,
    input wire logic        route_valid_o,
    input wire logic        route_local_o,
    input wire logic [3:0]  route_dir_o,
    // Configuration outputs
    input wire logic        header_one_byte_o,
    input wire logic [15:0] node_id_o,
    input wire logic        tile_reset_o,
    input wire logic        pll_relock_wait_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_wr(logic [7:0] a);
        cfg_req_i && cfg_write_i && cfg_addr_i == a;
    endsequence
    sequence s_wr_ok(logic [7:0] a);
        s_wr(a) ##1 !cfg_error_o;
    endsequence
    a_ro_write_err: assert property (
        cfg_req_i && cfg_write_i && cfg_addr_i inside {8'h00, 8'h01, 8'h09, 8'h0A}
        |=> cfg_ack_o && cfg_error_o) else $error("read-only write not refused");
    a_err_with_ack: assert property (
        cfg_error_o |-> cfg_ack_o) else $error("error without ack");
    a_node_id_wr: assert property (
        s_wr_ok(8'h05) |-> node_id_o == $past(cfg_wdata_i[15:0])) else $error("node id");
    a_hdr_change: assert property (
        $changed(header_one_byte_o) |-> $past(cfg_req_i && cfg_write_i && cfg_addr_i == 8'h04))
        else $error("header mode changed alone");
    a_reset_pulse: assert property (
        tile_reset_o |=> !tile_reset_o) else $error("tile reset too long");
    a_reset_cause: assert property (
        $rose(tile_reset_o) |-> $past(cfg_req_i && cfg_write_i && cfg_addr_i == 8'h06))
        else $error("tile reset without pll write");
    a_no_reset_bit: assert property (
        s_wr_ok(8'h06) |-> tile_reset_o == !$past(cfg_wdata_i[31])) else $error("reset bit");
    a_relock_bit: assert property (
        !pll_relock_wait_o ##0 s_wr_ok(8'h06) |-> pll_relock_wait_o == !$past(cfg_wdata_i[30]))
        else $error("relock wait bit");
    a_route_valid: assert property (
        route_valid_o == $past(route_req_i)) else $error("route valid");
    a_route_local: assert property (
        route_req_i && !cfg_req_i && route_dest_i == node_id_o
        |=> route_local_o && route_dir_o == 4'h0) else $error("local route");
endmodule : sncr_regs_sva

bind sncr_regs sncr_regs_sva sncr_regs_sva_inst (.clk_i, .reset_n_i, .cfg_req_i, .cfg_write_i,
    .cfg_addr_i, .cfg_wdata_i, .cfg_ack_o, .cfg_error_o, .route_req_i, .route_dest_i,
    .route_valid_o, .route_local_o, .route_dir_o, .header_one_byte_o, .node_id_o,
    .tile_reset_o, .pll_relock_wait_o);

// File: dv/sncr_pll_model.sv
// Behavioural PLL lock source seen by the bank
`timescale 1ns/1ps
module sncr_pll_model #(
    parameter int LOCK_DLY = 10
) (
    input  wire logic clk_i,
    input  wire logic relock_req_i,
    output logic      locked_o
);
    logic prev;
    int   cnt;
    initial begin
        locked_o = 1'b1;
        prev = 1'b0;
        cnt = 0;
    end
    // Lock lost each time the relock wait request rises, regained after a fixed settle time
    always @(posedge clk_i) begin
        prev <= relock_req_i;
        if (relock_req_i && !prev) begin
            locked_o <= 1'b0;
            cnt <= LOCK_DLY;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                locked_o <= 1'b1;
            end
        end
    end
endmodule : sncr_pll_model

// File: dv/tb_top.sv
// Self-checking bench of the node configuration bank
`timescale 1ns/1ps
module tb_top;
    localparam int LOCK_DLY = 10;
    logic        clk_i, reset_n_i, cfg_req_i, cfg_write_i, cfg_ack_o, cfg_error_o;
    logic [7:0]  cfg_addr_i, boot_control_pins_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o;
    logic        pll_locked_i, route_req_i, route_valid_o, route_local_o, header_one_byte_o;
    logic        pll_bypass_o, boot_from_jtag_o, tile_reset_o, pll_relock_wait_o;
    logic [13:0] otp_user_code_i;
    logic [1:0]  debug_source_i;
    logic [15:0] route_dest_i, node_id_o, switch_clk_div_o, ref_clk_div_o;
    logic [3:0]  route_dir_o;
    logic [2:0]  pll_out_div_o;
    logic [12:0] pll_fb_mult_o;
    logic [6:0]  pll_in_div_o;
    int          num_errors = 0;
    int          checked = 0;

    sncr_regs #(.PLL_BLANK_CYCLES(16'h0008)) sncr_regs_inst (.clk_i, .reset_n_i, .cfg_req_i,
        .cfg_write_i, .cfg_addr_i, .cfg_wdata_i, .cfg_ack_o, .cfg_error_o, .cfg_rdata_o,
        .boot_control_pins_i, .pll_locked_i, .otp_user_code_i, .debug_source_i, .route_req_i,
        .route_dest_i, .route_valid_o, .route_local_o, .route_dir_o, .header_one_byte_o,
        .node_id_o, .pll_bypass_o, .boot_from_jtag_o, .pll_out_div_o, .pll_fb_mult_o,
        .pll_in_div_o, .switch_clk_div_o, .ref_clk_div_o, .tile_reset_o, .pll_relock_wait_o);
    sncr_pll_model #(.LOCK_DLY(LOCK_DLY)) sncr_pll_model_inst (.clk_i,
        .relock_req_i(pll_relock_wait_o), .locked_o(pll_locked_i));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // One access; answer sampled once the ack edge has settled
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic xe, output logic [31:0] rv);
        @(posedge clk_i);
        cfg_req_i <= 1'b1;
        cfg_write_i <= w;
        cfg_addr_i <= a;
        cfg_wdata_i <= d;
        @(posedge clk_i);
        cfg_req_i <= 1'b0;
        #1;
        chk("cfg_ack_o", 32'(cfg_ack_o), 32'h1);
        chk("cfg_error_o", 32'(cfg_error_o), 32'(xe));
        rv = cfg_rdata_o;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic xe);
        logic [31:0] v;
        acc(1'b0, a, 32'h0, xe, v);
        chk("cfg_rdata_o", v, e);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] v;
        acc(1'b1, a, d, xe, v);
    endtask : wr
    task automatic route(input logic [15:0] d, input logic l, input logic [3:0] dir);
        @(posedge clk_i);
        route_req_i <= 1'b1;
        route_dest_i <= d;
        @(posedge clk_i);
        route_req_i <= 1'b0;
        #1;
        chk("route_valid_o", 32'(route_valid_o), 32'h1);
        chk("route_local_o", 32'(route_local_o), 32'(l));
        chk("route_dir_o", 32'(route_dir_o), 32'(dir));
    endtask : route

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
    initial begin
        int n;
        reset_n_i = 1'b0;
        cfg_req_i = 1'b0;
        cfg_write_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_wdata_i = 32'h0;
        route_req_i = 1'b0;
        route_dest_i = 16'h0;
        boot_control_pins_i = 8'hA5;
        otp_user_code_i = 14'h2AB;
        debug_source_i = 2'h2;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(8'h00, 32'h00A5_0001, 1'b0);
        rd(8'h01, 32'h0008_0202, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h05, 32'h0, 1'b0);
        rd(8'h06, 32'h0, 1'b0);
        rd(8'h07, 32'h0, 1'b0);
        rd(8'h09, 32'h0000_0001, 1'b0);
        rd(8'h08, 32'h3, 1'b0);
        rd(8'h0A, {14'h2AB, 18'h0}, 1'b0);
        rd(8'h0C, 32'h0, 1'b0);
        rd(8'h0D, 32'h0, 1'b0);
        rd(8'h1F, 32'h2, 1'b0);
        rd(8'h02, 32'h0, 1'b1);
        $display("TEST reset values done");
        wr(8'h05, 32'hFFFF_1234, 1'b0);
        rd(8'h05, 32'h0000_1234, 1'b0);
        wr(8'h07, 32'hFFFF_ABCD, 1'b0);
        chk("switch_clk_div_o", 32'(switch_clk_div_o), 32'hABCD);
        wr(8'h08, 32'h5A5A_0007, 1'b0);
        chk("ref_clk_div_o", 32'(ref_clk_div_o), 32'h0007);
        rd(8'h08, 32'h0000_0007, 1'b0);
        wr(8'h0C, 32'h7654_3210, 1'b0);
        wr(8'h0D, 32'hFEDC_BA98, 1'b0);
        rd(8'h0C, 32'h7654_3210, 1'b0);
        rd(8'h0D, 32'hFEDC_BA98, 1'b0);
        wr(8'h10, 32'hFFFF_FFFF, 1'b0);
        rd(8'h10, 32'h0000_0003, 1'b0);
        wr(8'h00, 32'hFFFF_FFFF, 1'b1);
        rd(8'h00, 32'h00A5_0001, 1'b0);
        wr(8'h02, 32'h1, 1'b1);
        $display("TEST register access done");
        // Mismatch in every bit from n down: only bit n may pick the field
        for (n = 0; n < 16; n++) begin
            route(16'h1234 ^ (16'hFFFF >> (15 - n)), 1'b0, n[3:0]);
        end
        route(16'h1234, 1'b1, 4'h0);
        $display("TEST routing done");
        wr(8'h04, 32'h0000_0001, 1'b0);
        chk("header_one_byte_o", 32'(header_one_byte_o), 32'h1);
        wr(8'h06, 32'h3280_FE0F, 1'b0);
        chk("tile_reset_o", 32'(tile_reset_o), 32'h1);
        chk("pll_relock_wait_o", 32'(pll_relock_wait_o), 32'h1);
        chk("pll_bypass_o", 32'(pll_bypass_o), 32'h1);
        chk("boot_from_jtag_o", 32'(boot_from_jtag_o), 32'h1);
        chk("pll_out_div_o", 32'(pll_out_div_o), 32'h5);
        chk("pll_fb_mult_o", 32'(pll_fb_mult_o), 32'h0FE);
        chk("pll_in_div_o", 32'(pll_in_div_o), 32'h0F);
        @(posedge clk_i);
        #1;
        chk("tile_reset_o", 32'(tile_reset_o), 32'h0);
        n = 1;
        while (pll_relock_wait_o === 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("relock_span", 32'(n > LOCK_DLY && n < 200), 32'h1);
        wr(8'h06, 32'hC01F_FF7F, 1'b0);
        chk("tile_reset_o", 32'(tile_reset_o), 32'h0);
        chk("pll_relock_wait_o", 32'(pll_relock_wait_o), 32'h0);
        rd(8'h06, 32'hC000_FE0F, 1'b0);
        $display("TEST pll settings done");
        wr(8'h04, 32'h0000_0101, 1'b0);
        wr(8'h06, 32'h0, 1'b1);
        chk("tile_reset_o", 32'(tile_reset_o), 32'h0);
        wr(8'h05, 32'h0000_00AA, 1'b0);
        wr(8'h04, 32'h8000_0101, 1'b0);
        wr(8'h05, 32'h0000_0055, 1'b1);
        chk("node_id_o", 32'(node_id_o), 32'h00AA);
        wr(8'h04, 32'h0, 1'b1);
        rd(8'h04, 32'h8000_0101, 1'b0);
        chk("header_one_byte_o", 32'(header_one_byte_o), 32'h1);
        $display("TEST write locks done");
        report_and_stop();
    end
endmodule : tb_top
